/* File: rtl/lps_serial_latch.sv */
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module lps_serial_latch (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic serial_input_in,
    input wire logic shift_clock_in,
    input wire logic latch_strobe_in,
    input wire logic register_select_in,
    input wire logic blank_in,
    input wire logic pwm_reference_clock_in,
    input wire logic [lps_pkg::LPS_CHANNELS-1:0] led_sense_low_in,
    output logic serial_output_out,
    output logic [lps_pkg::LPS_CHANNELS-1:0] sink_on_out,
    output logic [lps_pkg::LPS_DC_LEN-1:0] current_trim_out,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    import lps_pkg::*;

    typedef struct packed {
        logic [LPS_GS_LEN-1:0] gs_shift;
        logic [LPS_GS_LEN-1:0] gs_latch;
        logic [LPS_DC_LEN-1:0] trim_shift;
        logic [LPS_DC_LEN-1:0] trim_latch;
        logic status_pending;
        logic [LPS_GS_BITS-1:0] gs_count;
        logic [LPS_CHANNELS-1:0] open_led_flag;
        logic [LPS_CHANNELS-1:0] sink_on;
        logic serial_output;
        logic [31:0] ctrl;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lps_state_t;

    lps_state_t st_reg;
    lps_state_t st_next;

    logic sel_lvl, blank_lvl;
    logic sclk_rise, strobe_rise, strobe_fall, ref_rise;
    logic sin_lvl;

    lps_edge_sync u_sync_sin (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .async_in(serial_input_in), .level_out(sin_lvl), .rise_out(), .fall_out());
    lps_edge_sync u_sync_sclk (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .async_in(shift_clock_in), .level_out(), .rise_out(sclk_rise), .fall_out());
    lps_edge_sync u_sync_strobe (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .async_in(latch_strobe_in), .level_out(), .rise_out(strobe_rise),
        .fall_out(strobe_fall));
    lps_edge_sync u_sync_sel (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .async_in(register_select_in), .level_out(sel_lvl), .rise_out(), .fall_out());
    lps_edge_sync u_sync_blank (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .async_in(blank_in), .level_out(blank_lvl), .rise_out(), .fall_out());
    lps_edge_sync u_sync_ref (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .async_in(pwm_reference_clock_in), .level_out(), .rise_out(ref_rise),
        .fall_out());

    logic [LPS_CHANNELS-1:0] sense_lvl;
    genvar gi;
    generate
        for (gi = 0; gi < LPS_CHANNELS; gi++)
        begin : g_sense
            lps_edge_sync u_sync_sense (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
                .async_in(led_sense_low_in[gi]), .level_out(sense_lvl[gi]),
                .rise_out(), .fall_out());
        end
    endgenerate

    logic therm_err, therm_warn;
    logic [LPS_SID_LEN-1:0] status_word;
    assign therm_err = st_reg.ctrl[LPS_CTRL_THERM_ERR_BIT];
    assign therm_warn = st_reg.ctrl[LPS_CTRL_THERM_WARN_BIT];
    // Status word layout: error, warning, then open flags channel 15 down to 0
    assign status_word = {therm_err, therm_warn, st_reg.open_led_flag};

    always_comb
    begin
        logic [LPS_GS_BITS-1:0] cnt_new;
        logic [LPS_GS_BITS-1:0] chan_val;
        logic [31:0] rd;
        logic wr_fire;
        cnt_new = '0;
        chan_val = '0;
        rd = '0;
        wr_fire = 1'b0;
        st_next = st_reg;

        // Shift path; status load replaces the first grayscale shift after the strobe falls, unless a trim shift comes first
        if (sclk_rise)
        begin
            if (sel_lvl)
            begin
                st_next.trim_shift = {st_reg.trim_shift[LPS_DC_LEN-2:0], sin_lvl};
                // A trim shift drops the pending load, but the trim strobe's fall sets it again for the next grayscale frame
                st_next.status_pending = 1'b0;
            end
            else if (st_reg.status_pending)
            begin
                st_next.gs_shift[LPS_GS_LEN-1 -: LPS_SID_LEN] = status_word;
                st_next.status_pending = 1'b0;
            end
            else
                st_next.gs_shift = {st_reg.gs_shift[LPS_GS_LEN-2:0], sin_lvl};
        end
        if (strobe_fall)
            st_next.status_pending = 1'b1;
        if (strobe_rise)
        begin
            if (sel_lvl)
                st_next.trim_latch = st_reg.trim_shift;
            else
                st_next.gs_latch = st_reg.gs_shift;
        end

        // Grayscale counter held at zero while blanked
        if (blank_lvl)
            st_next.gs_count = '0;
        else if (ref_rise && st_reg.gs_count != LPS_GS_MAX)
            st_next.gs_count = st_reg.gs_count + 12'h001;
        cnt_new = st_next.gs_count;

        for (int i = 0; i < LPS_CHANNELS; i++)
        begin
            chan_val = st_reg.gs_latch[i*LPS_GS_BITS +: LPS_GS_BITS];
            if (blank_lvl || therm_err)
                st_next.sink_on[i] = 1'b0;
            else
                // On from count 1 through the latched value; a new latch takes effect at once
                st_next.sink_on[i] = (chan_val != '0) && (cnt_new != '0)
                                     && (cnt_new <= chan_val);
            // Only channels driving at the check edge are tested
            if (ref_rise && !blank_lvl && cnt_new == LPS_OPEN_CHECK_EDGE)
                st_next.open_led_flag[i] = st_next.sink_on[i] & sense_lvl[i];
        end

        st_next.serial_output = sel_lvl ? st_next.trim_shift[LPS_DC_LEN-1]
                               : st_next.gs_shift[LPS_GS_LEN-1];

        // AXI4-Lite write path
        if (s_axi_awvalid && !st_reg.aw_held)
        begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_held)
        begin
            st_next.w_held = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        wr_fire = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
        if (wr_fire)
        begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = LPS_RESP_OKAY;
            if (st_reg.aw_addr == LPS_REG_CTRL)
            begin
                for (int b = 0; b < 4; b++)
                    if (st_reg.w_strb[b])
                        st_next.ctrl[b*8 +: 8] = st_reg.w_data[b*8 +: 8];
            end
            else
                st_next.bresp = LPS_RESP_SLVERR;
        end
        if (st_reg.bvalid && s_axi_bready)
            st_next.bvalid = 1'b0;

        // AXI4-Lite read path
        if (s_axi_arvalid && !st_reg.rvalid)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp = LPS_RESP_OKAY;
            case (s_axi_araddr)
                LPS_REG_CTRL: rd = st_reg.ctrl;
                LPS_REG_STATUS: rd = {14'h0000, status_word};
                LPS_REG_COUNT: rd = {20'h0_0000, st_reg.gs_count};
                default:
                begin
                    rd = '0;
                    st_next.rresp = LPS_RESP_SLVERR;
                end
            endcase
            st_next.rdata = rd;
        end
        else if (st_reg.rvalid && s_axi_rready)
            st_next.rvalid = 1'b0;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            st_reg <= '0;
            st_reg.ctrl <= LPS_CTRL_RESET;
        end
        else
            st_reg <= st_next;
    end

    assign serial_output_out = st_reg.serial_output;
    assign sink_on_out = st_reg.sink_on;
    assign current_trim_out = st_reg.trim_latch;
    assign s_axi_awready = !st_reg.aw_held;
    assign s_axi_wready = !st_reg.w_held;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

    // Checks
    sequence seq_strobe_gs;
        strobe_rise && !sel_lvl;
    endsequence
    AST_GS_LATCH: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        seq_strobe_gs |=> st_reg.gs_latch == $past(st_reg.gs_shift))
        else $error("grayscale latch not loaded");
    AST_TRIM_LATCH: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        strobe_rise && sel_lvl |=> current_trim_out == $past(st_reg.trim_shift))
        else $error("trim latch not loaded");
    AST_BLANK_OFF: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        blank_lvl |=> sink_on_out == '0)
        else $error("sink on while blanked");
    AST_COUNT_HOLD: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        blank_lvl |=> st_reg.gs_count == '0)
        else $error("counter not held at zero");
    AST_COUNT_STEP: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        !blank_lvl && ref_rise && st_reg.gs_count != LPS_GS_MAX
        |=> st_reg.gs_count == $past(st_reg.gs_count) + 12'h001)
        else $error("counter did not step");
    AST_ZERO_OFF: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        ref_rise && st_reg.gs_latch[11:0] == '0 && !strobe_rise |=> !sink_on_out[0])
        else $error("zero value turned on");
    AST_THERM_OFF: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        therm_err |=> sink_on_out == '0)
        else $error("drivers on during thermal error");
    AST_STATUS_LOAD: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        sclk_rise && !sel_lvl && st_reg.status_pending && !strobe_rise
        |=> st_reg.gs_shift[LPS_GS_LEN-1 -: LPS_SID_LEN] == $past(status_word)
            && st_reg.gs_shift[LPS_GS_LEN-LPS_SID_LEN-1:0]
               == $past(st_reg.gs_shift[LPS_GS_LEN-LPS_SID_LEN-1:0]))
        else $error("status load wrong");
    AST_SERIAL_OUTPUT_MSB: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        !sel_lvl && $stable(sel_lvl) |-> serial_output_out == st_reg.gs_shift[LPS_GS_LEN-1])
        else $error("serial output not MSB");
endmodule

/* File: inc/lps_pkg.sv */
package lps_pkg;
    localparam int LPS_CHANNELS = 16;
    localparam int LPS_GS_BITS = 12;
    localparam int LPS_DC_BITS = 6;
    localparam int LPS_GS_LEN = 192;
    localparam int LPS_DC_LEN = 96;
    localparam int LPS_SID_LEN = 18;
    localparam logic [11:0] LPS_GS_MAX = 12'h0fff;
    localparam logic [11:0] LPS_OPEN_CHECK_EDGE = 12'h0021;
    // AXI4-Lite register byte offsets
    localparam logic [7:0] LPS_REG_CTRL = 8'h00;
    localparam logic [7:0] LPS_REG_STATUS = 8'h04;
    localparam logic [7:0] LPS_REG_COUNT = 8'h08;
    localparam logic [31:0] LPS_CTRL_RESET = 32'h0000_0000;
    localparam int LPS_CTRL_THERM_ERR_BIT = 0;
    localparam int LPS_CTRL_THERM_WARN_BIT = 1;
    localparam logic [1:0] LPS_RESP_OKAY = 2'b00;
    localparam logic [1:0] LPS_RESP_SLVERR = 2'b10;
endpackage

/* File: rtl/lps_edge_sync.sv */
`timescale 1ns/10ps
// Two-flop synchroniser with rising and falling edge pulses
module lps_edge_sync (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } lps_sync_state_t;
    lps_sync_state_t st_reg;
    lps_sync_state_t st_next;
    always_comb
    begin
        st_next.meta = async_in;
        st_next.sync = st_reg.meta;
        st_next.last = st_reg.sync;
    end
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
    assign level_out = st_reg.sync;
    assign rise_out = st_reg.sync & ~st_reg.last;
    assign fall_out = ~st_reg.sync & st_reg.last;
endmodule

/* File: test/lps_host_model.sv */
`timescale 1ns/10ps
module lps_host_model (
    input wire logic clk_sys_in,
    output logic serial_input_out,
    output logic shift_clock_out,
    output logic latch_strobe_out,
    output logic register_select_out,
    output logic blank_out,
    output logic pwm_reference_clock_out
);
    initial
    begin
        serial_input_out = 1'b0;
        shift_clock_out = 1'b0;
        latch_strobe_out = 1'b0;
        register_select_out = 1'b0;
        blank_out = 1'b1;
        pwm_reference_clock_out = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    // 800 ns per bit; the shift clock rests low between frames
    task automatic sclk_pulse(input logic b);
        serial_input_out <= b;
        wait_clk(3);
        shift_clock_out <= 1'b1;
        wait_clk(5);
        shift_clock_out <= 1'b0;
    endtask
    task automatic load(input logic sel, input logic [191:0] d, input int n);
        wait_clk(2);
        // Select moves only with the shift clock low, long after the last strobe
        register_select_out <= sel;
        wait_clk(2);
        for (int i = n - 1; i >= 0; i--)
            sclk_pulse(d[i]);
        wait_clk(3);
        latch_strobe_out <= 1'b1;
        wait_clk(4);
        latch_strobe_out <= 1'b0;
        wait_clk(4);
    endtask
    task automatic pwm(input int n);
        repeat (n)
        begin
            pwm_reference_clock_out <= 1'b1;
            wait_clk(4);
            pwm_reference_clock_out <= 1'b0;
            wait_clk(4);
        end
    endtask
    task automatic set_blank(input logic v);
        blank_out <= v;
        wait_clk(4);
    endtask
endmodule

/* File: test/lps_serial_latch_tb.sv */
`timescale 1ns/10ps
module lps_serial_latch_tb;
    import lps_pkg::*;
    logic clk_sys_in, srst_in, sdi, sclk, strb, sel, blank, pwm_reference_clock, sdo;
    logic [15:0] sense, sink;
    logic [95:0] trim, tv;
    logic awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat, seed;
    logic [3:0] ws;
    logic [1:0] bresp, rresp;
    logic [33:0] rq[$];
    logic [11:0] gv[16];
    logic [191:0] gsd;
    logic [17:0] st;
    int fails, samples_checked;
    lps_host_model i_lps_host_model (.clk_sys_in(clk_sys_in), .serial_input_out(sdi),
        .shift_clock_out(sclk), .latch_strobe_out(strb), .register_select_out(sel),
        .blank_out(blank), .pwm_reference_clock_out(pwm_reference_clock));
    lps_serial_latch i_lps_serial_latch (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .serial_input_in(sdi), .shift_clock_in(sclk), .latch_strobe_in(strb),
        .register_select_in(sel), .blank_in(blank), .pwm_reference_clock_in(pwm_reference_clock),
        .led_sense_low_in(sense), .serial_output_out(sdo), .sink_on_out(sink),
        .current_trim_out(trim), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp));
    initial
    begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    function automatic logic [15:0] exp_on(input int k);
        logic [15:0] r;
        for (int i = 0; i < 16; i++)
            r[i] = (gv[i] != 0) && (k >= 1) && (k <= gv[i]);
        return r;
    endfunction
    task automatic chk(input logic [95:0] g, input logic [95:0] e);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        br <= 1'b1;
        do
        begin
            @(posedge clk_sys_in);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end
        while (bv !== 1'b1);
        br <= 1'b0;
        chk({94'b0, bresp}, {94'b0, LPS_RESP_OKAY});
        @(posedge clk_sys_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        arv <= 1'b1;
        ara <= a;
        rr <= 1'b1;
        do
        begin
            @(posedge clk_sys_in);
            if (arr) arv <= 1'b0;
        end
        while (rv !== 1'b1);
        rr <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    // The read data and its note pair up at the edge where the beat is taken
    always @(posedge clk_sys_in)
        if (rv === 1'b1 && rr === 1'b1 && rq.size() > 0)
            chk({62'b0, rresp, rdat}, {62'b0, rq.pop_front()});
    initial
    begin
        #2000000;
        fails++;
        stop_test();
    end
    initial
    begin
        srst_in = 1'b1;
        sense = 16'h0000;
        {awv, wv, br, arv, rr} = 5'h00;
        {awa, ara, wd, ws} = {8'h00, 8'h00, 32'h0000_0000, 4'hf};
        seed = 32'h6ffd;
        repeat (20) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        chk({80'b0, sink}, 96'h0);
        rd(LPS_REG_CTRL, {LPS_RESP_OKAY, LPS_CTRL_RESET});
        rd(8'h0c, {LPS_RESP_SLVERR, 32'h0000_0000});
        ws <= 4'h2;
        wr(LPS_REG_CTRL, 32'h1234_5678);
        rd(LPS_REG_CTRL, {LPS_RESP_OKAY, 32'h0000_5600});
        ws <= 4'hf;
        wr(LPS_REG_CTRL, 32'h0000_0000);
        $display("reset test done");
        for (int i = 0; i < 3; i++)
        begin
            seed = xs(seed);
            tv = {tv[63:0], seed};
        end
        i_lps_host_model.load(1'b1, {96'b0, tv}, 96);
        chk(trim, tv);
        $display("trim test done");
        for (int i = 0; i < 16; i++)
            gv[i] = 12'h000;
        {gv[0], gv[1], gv[2], gv[14], gv[15]} = {12'd1, 12'd3, 12'd40, 12'd32, LPS_GS_MAX};
        for (int i = 0; i < 16; i++)
            gsd[12*i +: 12] = gv[i];
        i_lps_host_model.load(1'b0, gsd, 192);
        i_lps_host_model.pwm(3);
        chk({80'b0, sink}, 96'h0);
        rd(LPS_REG_COUNT, {LPS_RESP_OKAY, 32'h0000_0000});
        wr(LPS_REG_CTRL, 32'h0000_0002);
        seed = xs(seed);
        sense <= seed[15:0] | 16'h0004;
        i_lps_host_model.set_blank(1'b0);
        for (int k = 1; k <= 41; k++)
        begin
            i_lps_host_model.pwm(1);
            chk({80'b0, sink}, {80'b0, exp_on(k)});
        end
        rd(LPS_REG_COUNT, {LPS_RESP_OKAY, 32'h0000_0029});
        st = {1'b0, 1'b1, exp_on(33) & sense};
        rd(LPS_REG_STATUS, {LPS_RESP_OKAY, 14'b0, st});
        for (int k = 1; k <= 19; k++)
        begin
            i_lps_host_model.sclk_pulse(1'b0);
            chk({95'b0, sdo}, {95'b0, (k <= 18) ? st[18-k] : gsd[173]});
        end
        $display("display and status test done");
        wr(LPS_REG_CTRL, 32'h0000_0001);
        repeat (4) @(posedge clk_sys_in);
        chk({80'b0, sink}, 96'h0);
        rd(LPS_REG_STATUS, {LPS_RESP_OKAY, 14'b0, 2'b10, 16'h0004});
        wr(LPS_REG_CTRL, 32'h0000_0000);
        i_lps_host_model.set_blank(1'b1);
        chk({80'b0, sink}, 96'h0);
        rd(LPS_REG_COUNT, {LPS_RESP_OKAY, 32'h0000_0000});
        $display("thermal and blank test done");
        i_lps_host_model.set_blank(1'b0);
        i_lps_host_model.pwm(2);
        for (int i = 0; i < 16; i++)
            gv[i] = (i == 0) ? 12'd5 : 12'd0;
        for (int i = 0; i < 16; i++)
            gsd[12*i +: 12] = gv[i];
        // Latching mid-display is unsafe for a real panel; done here on purpose
        i_lps_host_model.load(1'b0, gsd, 192);
        chk({80'b0, sink}, {80'b0, exp_on(2)});
        $display("mid-display latch test done");
        stop_test();
    end
endmodule
